// [hw/pis_regs.svh]
// Register offsets, field positions, reset values and timing counts
// for the pin interrupt select and sense block.
// Assumes a 50 MHz system clock and byte addresses on an 8-bit port.
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH

`define PIS_NPINS          9
`define PIS_ADDR_W         8
`define PIS_DATA_W         32

`define PIS_OFS_DIR        8'h08
`define PIS_OFS_IRQE       8'h10
`define PIS_OFS_ISEN       8'h14
`define PIS_OFS_IMODE      8'h18
`define PIS_OFS_IBES       8'h1C
`define PIS_OFS_IDBE       8'h20
`define PIS_OFS_EVT_STAT   8'h24
`define PIS_OFS_EVT_CLR    8'h28
`define PIS_OFS_EVT_EN     8'h2C
`define PIS_OFS_PIN_LVL    8'h30

`define PIS_EVT_BIT        0

`define PIS_RST_DIR        9'h1FF
`define PIS_RST_CFG        9'h000

`define PIS_CLK_PERIOD_NS  20
`define PIS_DB_TICK_NS     1000
`define PIS_DB_TICK_CYC    ((`PIS_DB_TICK_NS + `PIS_CLK_PERIOD_NS - 1) / `PIS_CLK_PERIOD_NS)
`define PIS_DB_STABLE      4

`endif

// [hw/pis_pkg.sv]
// Types shared by the pin interrupt select and sense block.
// Assumes pis_regs.svh is on the include path.
`include "pis_regs.svh"

package pis_pkg;

  typedef logic [`PIS_NPINS-1:0]  pis_pin_vec_type;
  typedef logic [`PIS_DATA_W-1:0] pis_word_type;
  typedef logic [`PIS_ADDR_W-1:0] pis_addr_type;

  // One-hot register select used by the address decoder
  typedef enum logic [9:0] {
    PIS_SEL_NONE  = 10'h000,
    PIS_SEL_DIR   = 10'h001,
    PIS_SEL_IRQE  = 10'h002,
    PIS_SEL_ISEN  = 10'h004,
    PIS_SEL_IMODE = 10'h008,
    PIS_SEL_IBES  = 10'h010,
    PIS_SEL_IDBE  = 10'h020,
    PIS_SEL_STAT  = 10'h040,
    PIS_SEL_CLR   = 10'h080,
    PIS_SEL_EVTEN = 10'h100,
    PIS_SEL_LVL   = 10'h200
  } pis_sel_type;

endpackage

// [hw/pis_pin_filter.sv]
// One pin: two-flop synchroniser followed by a tick-driven debounce filter.
// Assumes tick_i is a one-cycle enable from a divider in the parent.
`timescale 1ns/100ps
`include "pis_regs.svh"

module pis_pin_filter #(
  parameter int unsigned STABLE_TICKS = `PIS_DB_STABLE
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic tick_i,
  input  wire logic pin_i,
  output logic      sync_o,
  output logic      filt_o
);

  localparam int unsigned CW = $clog2(STABLE_TICKS + 1);

  logic          meta_q;
  logic          sync_q;
  logic          filt_q;
  logic [CW-1:0] cnt_q;

  // Stage one feeds only stage two
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // A level must hold for STABLE_TICKS ticks in a row before it passes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (sync_q == filt_q) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      if (cnt_q == CW'(STABLE_TICKS - 1)) begin
        filt_q <= sync_q;
        cnt_q  <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign sync_o = sync_q;
  assign filt_o = filt_q;

endmodule

// [hw/pis_top.sv]
// Pin interrupt source selection and sense logic for nine input pins.
// Assumes synchronous register port strobes and pins driven from outside.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "pis_regs.svh"

module pis_top
  import pis_pkg::*;
#(
  parameter int unsigned DB_TICK_CYC  = `PIS_DB_TICK_CYC,
  parameter int unsigned STABLE_TICKS = `PIS_DB_STABLE
) (
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire pis_addr_type    addr_i,
  input  wire pis_word_type    wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output pis_word_type         rdata_o,
  input  wire pis_pin_vec_type pin_i,
  output logic                 irq_o,
  output logic                 pin_event_flag_o
);

  localparam int unsigned NP  = `PIS_NPINS;
  localparam int unsigned DVW = $clog2(DB_TICK_CYC + 1);

  pis_pin_vec_type pin_direction_q;
  pis_pin_vec_type pin_interrupt_enable_q;
  pis_pin_vec_type pin_interrupt_sense_q;
  pis_pin_vec_type pin_level_edge_mode_q;
  pis_pin_vec_type pin_both_edge_select_q;
  pis_pin_vec_type pin_debounce_enable_q;
  logic            evt_stat_q;
  logic            evt_en_q;
  pis_word_type    rdata_q;
  logic            irq_q;
  logic            evt_flag_q;
  logic [DVW-1:0]  div_q;
  logic            tick_q;

  pis_pin_vec_type sync_lvl;
  pis_pin_vec_type filt_lvl;
  pis_pin_vec_type cur_lvl;
  pis_pin_vec_type prev_q;
  pis_pin_vec_type hit;
  pis_pin_vec_type armed;
  logic            any_hit;
  logic            evt_clr;
  pis_sel_type     sel;
  pis_pin_vec_type wr_bits;

  // Only the low pin bits are stored; upper bits are dropped on write
  assign wr_bits = wdata_i[NP-1:0];

  always_comb begin
    case (addr_i)
      `PIS_OFS_DIR:      sel = PIS_SEL_DIR;
      `PIS_OFS_IRQE:     sel = PIS_SEL_IRQE;
      `PIS_OFS_ISEN:     sel = PIS_SEL_ISEN;
      `PIS_OFS_IMODE:    sel = PIS_SEL_IMODE;
      `PIS_OFS_IBES:     sel = PIS_SEL_IBES;
      `PIS_OFS_IDBE:     sel = PIS_SEL_IDBE;
      `PIS_OFS_EVT_STAT: sel = PIS_SEL_STAT;
      `PIS_OFS_EVT_CLR:  sel = PIS_SEL_CLR;
      `PIS_OFS_EVT_EN:   sel = PIS_SEL_EVTEN;
      `PIS_OFS_PIN_LVL:  sel = PIS_SEL_LVL;
      default:           sel = PIS_SEL_NONE;
    endcase
  end

  // Direction: 1 marks a pin as input; all pins come up as inputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_direction_q <= `PIS_RST_DIR;
    end else if (wr_i && sel == PIS_SEL_DIR) begin
      pin_direction_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_interrupt_enable_q <= `PIS_RST_CFG;
    end else if (wr_i && sel == PIS_SEL_IRQE) begin
      pin_interrupt_enable_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_interrupt_sense_q <= `PIS_RST_CFG;
    end else if (wr_i && sel == PIS_SEL_ISEN) begin
      pin_interrupt_sense_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_level_edge_mode_q <= `PIS_RST_CFG;
    end else if (wr_i && sel == PIS_SEL_IMODE) begin
      pin_level_edge_mode_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_both_edge_select_q <= `PIS_RST_CFG;
    end else if (wr_i && sel == PIS_SEL_IBES) begin
      pin_both_edge_select_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_debounce_enable_q <= `PIS_RST_CFG;
    end else if (wr_i && sel == PIS_SEL_IDBE) begin
      pin_debounce_enable_q <= wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      evt_en_q <= 1'b0;
    end else if (wr_i && sel == PIS_SEL_EVTEN) begin
      evt_en_q <= wdata_i[`PIS_EVT_BIT];
    end
  end

  // Debounce sample rate: one-cycle tick every DB_TICK_CYC clocks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DVW'(DB_TICK_CYC - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + DVW'(1);
      tick_q <= 1'b0;
    end
  end

  for (genvar i = 0; i < NP; i++) begin : g_pin
    pis_pin_filter #(
      .STABLE_TICKS (STABLE_TICKS)
    ) u_filt (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .tick_i (tick_q),
      .pin_i  (pin_i[i]),
      .sync_o (sync_lvl[i]),
      .filt_o (filt_lvl[i])
    );

    logic rise;
    logic fall;
    logic edge_hit;
    logic lvl_hit;

    assign cur_lvl[i] = pin_debounce_enable_q[i] ? filt_lvl[i] : sync_lvl[i];

    assign rise = cur_lvl[i] & ~prev_q[i];
    assign fall = ~cur_lvl[i] & prev_q[i];

    // Sense picks the active level or edge
    assign lvl_hit  = pin_interrupt_sense_q[i] ? ~cur_lvl[i] : cur_lvl[i];
    assign edge_hit = pin_both_edge_select_q[i] ? (rise | fall) :
                      (pin_interrupt_sense_q[i] ? fall : rise);

    assign hit[i] = pin_level_edge_mode_q[i] ? edge_hit : lvl_hit;

    assign armed[i] = pin_interrupt_enable_q[i] & pin_direction_q[i];
  end

  // Previous sample of the selected level, for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= cur_lvl;
    end
  end

  assign any_hit = |(hit & armed);
  assign evt_clr = wr_i && sel == PIS_SEL_CLR && wdata_i[`PIS_EVT_BIT];

  // Set wins over a clear in the same cycle; a held level re-sets at once
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      evt_stat_q <= 1'b0;
    end else if (any_hit) begin
      evt_stat_q <= 1'b1;
    end else if (evt_clr) begin
      evt_stat_q <= 1'b0;
    end
  end

  // Outputs follow the status one cycle later so both come from flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      evt_flag_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      evt_flag_q <= evt_stat_q;
      irq_q      <= evt_stat_q & evt_en_q;
    end
  end

  // Read data stands for exactly one cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      case (sel)
        PIS_SEL_DIR:   rdata_q <= {{(32-NP){1'b0}}, pin_direction_q};
        PIS_SEL_IRQE:  rdata_q <= {{(32-NP){1'b0}}, pin_interrupt_enable_q};
        PIS_SEL_ISEN:  rdata_q <= {{(32-NP){1'b0}}, pin_interrupt_sense_q};
        PIS_SEL_IMODE: rdata_q <= {{(32-NP){1'b0}}, pin_level_edge_mode_q};
        PIS_SEL_IBES:  rdata_q <= {{(32-NP){1'b0}}, pin_both_edge_select_q};
        PIS_SEL_IDBE:  rdata_q <= {{(32-NP){1'b0}}, pin_debounce_enable_q};
        PIS_SEL_STAT:  rdata_q <= {31'h0000_0000, evt_stat_q};
        PIS_SEL_EVTEN: rdata_q <= {31'h0000_0000, evt_en_q};
        PIS_SEL_LVL:   rdata_q <= {{(32-NP){1'b0}}, cur_lvl};
        default:       rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o          = rdata_q;
  assign irq_o            = irq_q;
  assign pin_event_flag_o = evt_flag_q;

endmodule

// [testbench/pis_top_properties.sv]
// Port-level assertions for pis_top.
// Assumes a bind from the bench top file; watches top-level ports only.
`timescale 1ns/100ps

module pis_top_chk
  import pis_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire pis_addr_type    addr_i,
  input  wire pis_word_type    wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  input  wire pis_word_type    rdata_o,
  input  wire pis_pin_vec_type pin_i,
  input  wire logic            irq_o,
  input  wire logic            pin_event_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Reset itself is the cause here, so this one is never disabled
  property p_rst;
    disable iff (1'b0) srst_i |=> !irq_o && !pin_event_flag_o && rdata_o == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear in reset");
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_upper;
    rd_i |=> rdata_o[31:9] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wr_rd;
    (wr_i && addr_i == 8'h10) ##1 (rd_i && addr_i == 8'h10)
      |=> rdata_o == {23'h0, $past(wdata_i[8:0], 2)};
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("enable readback wrong");
  property p_unmapped;
    rd_i && (addr_i == 8'h00 || addr_i == 8'h28) |=> rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("empty address read nonzero");
  property p_irq_flag;
    irq_o |-> pin_event_flag_o;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq without event flag");
  property p_sticky;
    $fell(pin_event_flag_o) |-> $past(wr_i && addr_i == 8'h28, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped uncleared");
  property p_irq_fall;
    $fell(irq_o) |-> $past(wr_i, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped with no write");
endmodule

// [testbench/pis_pin_src.sv]
// Stand-in for the external signals on the nine pins.
// Assumes the bench calls drive; pins change just after a rising edge.
`timescale 1ns/100ps

module pis_pin_src
  import pis_pkg::*;
(
  input  wire logic       clk_i,
  output pis_pin_vec_type pin_o
);
  initial pin_o = '0;

  // Hold v for n cycles then restore; n of 0 leaves v standing
  task automatic drive(input pis_pin_vec_type v, input int n);
    pis_pin_vec_type old;
    old = pin_o;
    @(posedge clk_i);
    pin_o <= v;
    if (n > 0) begin
      repeat (n) @(posedge clk_i);
      pin_o <= old;
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// Bench for pis_top: registers, pin triggers, event flag and interrupt.
// Assumes the checker and pin source are compiled before this file.
`timescale 1ns/100ps

module tb_top
  import pis_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            srst_i = 1'b1;
  pis_addr_type    addr_i = '0;
  pis_word_type    wdata_i = '0;
  logic            wr_i = 1'b0;
  logic            rd_i = 1'b0;
  pis_word_type    rdata_o;
  pis_pin_vec_type pin_i;
  logic            irq_o;
  logic            pin_event_flag_o;
  int              err_total = 0;
  int              total_checks = 0;

  always #10 clk_i = ~clk_i;

  // Short debounce counts keep the run brief
  pis_top #(.DB_TICK_CYC(2), .STABLE_TICKS(2)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .irq_o(irq_o),
    .pin_event_flag_o(pin_event_flag_o));
  pis_pin_src src (.clk_i(clk_i), .pin_o(pin_i));

  task automatic chk(input pis_word_type seen, input pis_word_type exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic outs(input bit f, input bit q);
    chk(32'(pin_event_flag_o), 32'(f));
    chk(32'(irq_o), 32'(q));
  endtask
  task automatic wr(input pis_addr_type a, input pis_word_type d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input pis_addr_type a, input pis_word_type e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // Write then read with no gap, the tightest order the port allows
  task automatic wrrd(input pis_addr_type a, input pis_word_type d);
    wr(a, d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, d);
  endtask
  // c = {enable, input, edge, sense, both, debounce} for pin p alone
  task automatic run(input int p, input bit [5:0] c, input bit s0, input bit s1,
                     input int n, input bit e);
    pis_word_type m;
    m = 32'h1 << p;
    src.drive(s0 ? m[8:0] : 9'h000, 0);
    wr(8'h08, m & {32{c[4]}});
    wr(8'h10, m & {32{c[5]}});
    wr(8'h14, m & {32{c[2]}});
    wr(8'h18, m & {32{c[3]}});
    wr(8'h1C, m & {32{c[1]}});
    wr(8'h20, m & {32{c[0]}});
    wr(8'h2C, 32'h1);
    wait_cyc(20);
    wr(8'h28, 32'h1);
    wait_cyc(6);
    outs(1'b0, 1'b0);
    src.drive(s1 ? m[8:0] : 9'h000, n);
    wait_cyc(24);
    outs(e, e);
  endtask

  task automatic t_regs();
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h24, 32'h0);
    wrrd(8'h10, 32'h1FF);
    wrrd(8'h14, 32'h0A5);
    rd(8'h00, 32'h0);
  endtask
  task automatic t_level();
    run(0, 6'b110000, 1'b0, 1'b1, 0, 1'b1);
    run(8, 6'b110100, 1'b1, 1'b0, 0, 1'b1);
  endtask
  task automatic t_edge();
    run(1, 6'b111000, 1'b0, 1'b1, 0, 1'b1);
    run(4, 6'b111000, 1'b1, 1'b0, 0, 1'b0);
    run(5, 6'b111100, 1'b1, 1'b0, 0, 1'b1);
    run(6, 6'b111010, 1'b1, 1'b0, 0, 1'b1);
  endtask
  task automatic t_gate();
    run(3, 6'b010000, 1'b0, 1'b1, 0, 1'b0);
    run(3, 6'b100000, 1'b0, 1'b1, 0, 1'b0);
  endtask
  task automatic t_db();
    run(2, 6'b110001, 1'b0, 1'b1, 1, 1'b0);
    run(2, 6'b110001, 1'b0, 1'b1, 0, 1'b1);
  endtask
  task automatic t_irq();
    wr(8'h2C, 32'h0);
    wait_cyc(3);
    outs(1'b1, 1'b0);
    rd(8'h24, 32'h1);
    rd(8'h30, 32'h4);
    wr(8'h28, 32'h1);
    wait_cyc(3);
    outs(1'b1, 1'b0);
    src.drive(9'h000, 0);
    wait_cyc(20);
    wr(8'h28, 32'h1);
    wait_cyc(3);
    outs(1'b0, 1'b0);
  endtask

  // A reset in mid-run must drop configuration that software has set
  task automatic t_rst();
    wr(8'h10, 32'h1FF);
    wr(8'h14, 32'h1FF);
    srst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    outs(1'b0, 1'b0);
  endtask

  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_level();
    t_edge();
    t_gate();
    t_db();
    t_irq();
    t_rst();
    give_verdict();
  end
  // The scenarios need about 760 cycles; 5000 marks a hang
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule

bind pis_top pis_top_chk u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .irq_o(irq_o),
  .pin_event_flag_o(pin_event_flag_o));
